/* File: design/nci_regs.svh */
// Purpose: register map and field positions of the interrupt mask block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: event bits sit at 14:8 in both registers
`ifndef NCI_REGS_SVH
`define NCI_REGS_SVH
`define NCI_MASK_OFS 32'h0000_0000
`define NCI_STAT_OFS 32'h0000_0004
`define NCI_WORD_MSB 3'h2
`define NCI_FLD_LO 8
`define NCI_FLD_HI 14
`define NCI_FLD_W 7
`define NCI_IDX_TXERR 0
`define NCI_IDX_TXOK 1
`define NCI_IDX_RXOK 2
`define NCI_IDX_DESCRIPTOR_IRQ_REQUEST 3
`define NCI_IDX_FLT 4
`define NCI_IDX_HBL 5
`define NCI_IDX_BRTY 6
`define NCI_MASK_RST 7'h00
`define NCI_STAT_RST 7'h00
`define NCI_TRANS_NSEQ 2'h2
`define NCI_TRANS_SEQ 2'h3
`define NCI_RSVD_BIT 15
`define NCI_RESP_OKAY 1'h0
`endif

/* File: design/nci_pkg.sv */
// Purpose: types for the interrupt mask block
// Assumes: nci_regs.svh field widths
// Notes: whole module state is one packed struct
`include "nci_regs.svh"
package nci_pkg;
  typedef struct packed {
    logic [`NCI_FLD_W-1:0] mask;
    logic [`NCI_FLD_W-1:0] status;
    logic dpWr;
    logic dpMask;
    logic dpStat;
    logic [31:0] rdata;
  } nci_state_t;
endpackage

/* File: design/nci_interrupt_mask.sv */
// Purpose: interrupt enable mask, sticky event status and request output
// Assumes: single whole-word AHB-Lite transfers, zero wait states
// Notes: status bits clear by writing one; a same-cycle event wins
`timescale 1ns/1ps
`include "nci_regs.svh"
// Notes on behaviour
// - enable bit 14 lets a bus retry request raise the interrupt.
// - enable bit 13 lets a lost heartbeat raise the interrupt.
// - enable bit 12 lets a finished filter-memory load raise the interrupt.
// - enable bit 11 interrupts for descriptors carrying the per-packet request bit.
// - enable bit 10 lets each accepted received packet raise the interrupt.
// - enable bit 9 lets each transmit completion raise the interrupt.
// - enable bit 8 gates transmit errors; zero disables them.
module nci_interrupt_mask #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // event pulses from the controller
  input wire logic busRetryEvt,
  input wire logic heartbeatLostEvt,
  input wire logic filterLoadDoneEvt,
  input wire logic txDescDoneEvt,
  input wire logic descriptorIrqRequest,
  input wire logic rxAcceptedEvt,
  input wire logic txSuccessEvt,
  input wire logic txErrorEvt,
  // interrupt request
  output logic irqReq
);
  // both word offsets must fit in the decoded address
  if (ADDR_W < 3) begin : g_addrWidthBad
    $error("nci_interrupt_mask: ADDR_W too small");
  end

  nci_pkg::nci_state_t st_ff;
  nci_pkg::nci_state_t nxt_st;
  logic addrPhase;
  logic hitMask;
  logic hitStat;
  logic maskWr;
  logic statWr;
  logic [`NCI_FLD_W-1:0] evtVec;
  logic [`NCI_FLD_W-1:0] clrVec;
  logic [`NCI_FLD_W-1:0] wrField;
  logic irqCause;
  logic irqDrop;

  assign addrPhase = hsel && hready && (htrans == `NCI_TRANS_NSEQ || htrans == `NCI_TRANS_SEQ);
  // full compare, so aliases of the two words decode as unmapped
  assign hitMask = haddr == ADDR_W'(`NCI_MASK_OFS);
  assign hitStat = haddr == ADDR_W'(`NCI_STAT_OFS);
  assign maskWr = st_ff.dpWr && st_ff.dpMask;
  assign statWr = st_ff.dpWr && st_ff.dpStat;
  assign wrField = hwdata[`NCI_FLD_HI:`NCI_FLD_LO];
  assign clrVec = statWr ? wrField : '0;

  // per-packet events count only when the descriptor asked for one
  assign evtVec[`NCI_IDX_DESCRIPTOR_IRQ_REQUEST] = txDescDoneEvt && descriptorIrqRequest;
  assign evtVec[`NCI_IDX_BRTY] = busRetryEvt;
  assign evtVec[`NCI_IDX_HBL] = heartbeatLostEvt;
  assign evtVec[`NCI_IDX_FLT] = filterLoadDoneEvt;
  assign evtVec[`NCI_IDX_RXOK] = rxAcceptedEvt;
  assign evtVec[`NCI_IDX_TXOK] = txSuccessEvt;
  assign evtVec[`NCI_IDX_TXERR] = txErrorEvt;

  always_comb begin
    nxt_st = st_ff;
    // set beats clear so an event during a status write is kept
    nxt_st.status = (st_ff.status & ~clrVec) | evtVec;
    if (maskWr) begin
      nxt_st.mask = wrField;
    end
    nxt_st.dpWr = addrPhase && hwrite;
    nxt_st.dpMask = addrPhase && hitMask;
    nxt_st.dpStat = addrPhase && hitStat;
    nxt_st.rdata = '0;
    // bit 15 and unmapped words read as zero
    // next-state values, so a read right behind a write sees the register as that write left it
    if (addrPhase && !hwrite && hitMask) begin
      nxt_st.rdata[`NCI_FLD_HI:`NCI_FLD_LO] = nxt_st.mask;
    end else if (addrPhase && !hwrite && hitStat) begin
      nxt_st.rdata[`NCI_FLD_HI:`NCI_FLD_LO] = nxt_st.status;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{mask: `NCI_MASK_RST, status: `NCI_STAT_RST, dpWr: 1'b0, dpMask: 1'b0,
                 dpStat: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = `NCI_RESP_OKAY;
  assign hrdata = st_ff.rdata;
  // request follows pending and enabled conditions from flops only
  assign irqReq = |(st_ff.status & st_ff.mask);
  // only an event or a mask write can raise the request, only a write can drop it
  assign irqCause = |evtVec || maskWr;
  assign irqDrop = maskWr || statWr;

  sequence s_maskRead;
    addrPhase && !hwrite && hitMask;
  endsequence

  sequence s_statRead;
    addrPhase && !hwrite && hitStat;
  endsequence

  sequence s_maskWrite;
    addrPhase && hwrite && hitMask ##1 1'b1;
  endsequence

  a_retry_raises_irq: assert property (@(posedge clk) disable iff (sys_rst)
    busRetryEvt && st_ff.mask[`NCI_IDX_BRTY] && !maskWr |=> irqReq)
    else $error("bus retry did not raise request");

  a_heartbeat_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    heartbeatLostEvt |=> st_ff.status[`NCI_IDX_HBL] && (!st_ff.mask[`NCI_IDX_HBL] || irqReq))
    else $error("heartbeat event not latched or gated");

  a_hbl_raises_irq: assert property (@(posedge clk) disable iff (sys_rst)
    heartbeatLostEvt && st_ff.mask[`NCI_IDX_HBL] && !maskWr |=> irqReq)
    else $error("lost heartbeat did not raise request");

  a_filter_masked: assert property (@(posedge clk) disable iff (sys_rst)
    filterLoadDoneEvt && st_ff.mask == '0 && !maskWr |=> !irqReq)
    else $error("masked filter load raised request");

  a_filter_raises_irq: assert property (@(posedge clk) disable iff (sys_rst)
    filterLoadDoneEvt && st_ff.mask[`NCI_IDX_FLT] && !maskWr |=> irqReq)
    else $error("filter load done did not raise request");

  a_descriptor_irq_request_needs_req: assert property (@(posedge clk) disable iff (sys_rst)
    txDescDoneEvt && !descriptorIrqRequest && !st_ff.status[`NCI_IDX_DESCRIPTOR_IRQ_REQUEST] |=>
    !st_ff.status[`NCI_IDX_DESCRIPTOR_IRQ_REQUEST])
    else $error("descriptor without request set pending bit");

  a_descriptor_irq_request_raises_irq: assert property (@(posedge clk) disable iff (sys_rst)
    txDescDoneEvt && descriptorIrqRequest && st_ff.mask[`NCI_IDX_DESCRIPTOR_IRQ_REQUEST] && !maskWr |=> irqReq)
    else $error("per-packet request did not raise request");

  a_rx_raises_irq: assert property (@(posedge clk) disable iff (sys_rst)
    rxAcceptedEvt && st_ff.mask[`NCI_IDX_RXOK] && !maskWr |=> irqReq)
    else $error("accepted packet did not raise request");

  a_txok_raises_irq: assert property (@(posedge clk) disable iff (sys_rst)
    txSuccessEvt && st_ff.mask[`NCI_IDX_TXOK] && !maskWr |=> irqReq)
    else $error("transmit completion did not raise request");

  a_txerr_disable: assert property (@(posedge clk) disable iff (sys_rst)
    s_maskWrite ##0 !hwdata[`NCI_FLD_LO] |=> !st_ff.mask[`NCI_IDX_TXERR])
    else $error("transmit error enable not cleared by write");

  a_txerr_raises_irq: assert property (@(posedge clk) disable iff (sys_rst)
    txErrorEvt && st_ff.mask[`NCI_IDX_TXERR] && !maskWr |=> irqReq)
    else $error("transmit error did not raise request");

  a_mask_loads: assert property (@(posedge clk) disable iff (sys_rst)
    s_maskWrite |=> st_ff.mask == $past(wrField))
    else $error("mask write not applied");

  a_irq_fall_cause: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(irqReq) |-> $past(irqDrop))
    else $error("request dropped without a register write");

  a_irq_rise_cause: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(irqReq) |-> $past(irqCause))
    else $error("request raised without an event or mask write");

  a_quiet_in_reset: assert property (@(posedge clk)
    sys_rst |=> !irqReq)
    else $error("request high straight after reset");

  a_mask_readback: assert property (@(posedge clk) disable iff (sys_rst)
    s_maskRead |=> hrdata[`NCI_FLD_HI:`NCI_FLD_LO] == st_ff.mask && hrdata[`NCI_RSVD_BIT] == 1'b0)
    else $error("mask read back wrong");

  a_stat_readback: assert property (@(posedge clk) disable iff (sys_rst)
    s_statRead |=> hrdata[`NCI_FLD_HI:`NCI_FLD_LO] == st_ff.status && hrdata[`NCI_RSVD_BIT] == 1'b0)
    else $error("status read back wrong");

  // one sticky cell per event; a write of one clears it, an event in that cycle wins
  for (genvar gi = 0; gi < `NCI_FLD_W; gi++) begin : g_cell
    a_cell_holds: assert property (@(posedge clk) disable iff (sys_rst)
      st_ff.status[gi] && !clrVec[gi] |=> st_ff.status[gi])
      else $error("pending bit lost without a clear");

    a_cell_clears: assert property (@(posedge clk) disable iff (sys_rst)
      clrVec[gi] && !evtVec[gi] |=> !st_ff.status[gi])
      else $error("pending bit not cleared by a write of one");

    a_cell_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      evtVec[gi] |=> st_ff.status[gi])
      else $error("event not latched");

    a_cell_no_spurious: assert property (@(posedge clk) disable iff (sys_rst)
      !st_ff.status[gi] && !evtVec[gi] |=> !st_ff.status[gi])
      else $error("pending bit set without an event");

    a_cell_gated: assert property (@(posedge clk) disable iff (sys_rst)
      evtVec[gi] && !st_ff.mask[gi] && !maskWr && !irqReq && (evtVec & st_ff.mask) == '0 |=> !irqReq)
      else $error("disabled event raised request");
  end
endmodule

/* File: dv/tb_nci_interrupt_mask.sv */
// Purpose: self-checking bench for the interrupt mask block
// Assumes: zero-wait AHB-Lite slave, mask at 0x0, status at 0x4
// Notes: one event at a time, so each enable is seen in isolation
`timescale 1ns/1ps
`include "nci_regs.svh"
module tb_nci_interrupt_mask;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout;
  logic hresp;
  logic lastResp = 1'b0;
  logic irqReq;
  logic descReq = 1'b0;
  logic [6:0] evt = 7'h00;
  logic [31:0] bitVal;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  nci_interrupt_mask uut (.clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .busRetryEvt(evt[6]), .heartbeatLostEvt(evt[5]),
    .filterLoadDoneEvt(evt[4]), .txDescDoneEvt(evt[3]), .descriptorIrqRequest(descReq),
    .rxAcceptedEvt(evt[2]), .txSuccessEvt(evt[1]), .txErrorEvt(evt[0]), .irqReq(irqReq));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one single transfer; read data and response taken at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= `NCI_TRANS_NSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    lastResp = hresp;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
    check({31'h0, lastResp}, {31'h0, `NCI_RESP_OKAY});
  endtask
  task automatic irqchk(input logic exp);
    @(negedge clk);
    check({31'h0, irqReq}, {31'h0, exp});
    @(posedge clk);
  endtask
  // descriptor request qualifies only the per-packet event
  task automatic pulse(input int i, input logic req);
    evt[i] <= 1'b1;
    descReq <= req;
    @(posedge clk);
    evt <= 7'h00;
    descReq <= 1'b0;
    // one quiet edge, so a following pulse never drives evt twice in a time step
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    rdchk(`NCI_MASK_OFS, 32'h0000_0000);
    rdchk(`NCI_STAT_OFS, 32'h0000_0000);
    wr(`NCI_MASK_OFS, 32'hffff_ffff);
    rdchk(`NCI_MASK_OFS, 32'h0000_7f00);
    rdchk(32'h0000_0008, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      bitVal = 32'h0000_0001 << (i + 8);
      wr(`NCI_MASK_OFS, 32'hffff_00ff);
      pulse(i, 1'b1);
      irqchk(1'b0);
      rdchk(`NCI_STAT_OFS, bitVal);
      wr(`NCI_MASK_OFS, bitVal | 32'hffff_00ff);
      irqchk(1'b1);
      wr(`NCI_STAT_OFS, bitVal);
      irqchk(1'b0);
      pulse(i, 1'b1);
      irqchk(1'b1);
      wr(`NCI_STAT_OFS, bitVal);
    end
    // per-packet event without the descriptor request must not latch
    wr(`NCI_MASK_OFS, 32'h0000_7f00);
    pulse(3, 1'b0);
    irqchk(1'b0);
    rdchk(`NCI_STAT_OFS, 32'h0000_0000);
    // two pending sources: request drops only after the last is cleared
    pulse(2, 1'b0);
    pulse(1, 1'b0);
    wr(`NCI_STAT_OFS, 32'h0000_0400);
    irqchk(1'b1);
    wr(`NCI_STAT_OFS, 32'h0000_0200);
    irqchk(1'b0);
    give_verdict();
  end
endmodule
